//--- core/evd_regs.svh
// Register offsets, field positions, reset values and vector offsets for the dispatch block
//
// Functional notes
// - Frame length longword counts every byte including itself.
// - Flags bit 31 marks resumable; always set for corrected errors.
// - Flags bit 30 marks repeated corrected error; cleared for machine checks.
// - Word at +08 gives processor-section offset; 16 means no firmware data.
// - Processor offset equal to platform offset means no processor data.
// - Word at +12 gives platform offset; equal to length means none.
// - Logout pointer register gets frame offset from logout-area base.
// - Without a frame the logout pointer register holds all ones.
// - Table page frame comes from the table-base register.
// - Table is 512 to 2048 entries of sixteen bytes.
// - Low quadword of entry is fetched as the handler address.
// - High quadword of entry is fetched as the handler parameter.
// - Offsets 0 through 1FF0 hold all fixed vectors.
// - Faults dispatch at unchanged priority, kernel mode, kernel stack.
// - Floating-disabled uses offset 010; access violation uses 080.
// - Translation-not-valid uses offset 090.
// - Fault-on-read uses 0A0; fault-on-write uses 0B0.
// - Fault-on-execute uses 0C0.
// - Arithmetic trap uses 200; 210 to 230 stay unused.
// - Arithmetic traps dispatch at unchanged priority, kernel mode and stack.
// - Machine checks run kernel; level 20 system corrected, else 31.
`ifndef EVD_REGS_SVH
`define EVD_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define EVD_OFF_TABLE_BASE  8'h00
`define EVD_OFF_ERR_SUMMARY 8'h04
`define EVD_OFF_IPL         8'h08
`define EVD_OFF_STATUS      8'h0c
`define EVD_IPL_RESET       5'h00
`define EVD_BIT_PROC_PEND   0
`define EVD_BIT_SYS_PEND    1

// ----------------------------------------------------------------
// Logout frame layout
// ----------------------------------------------------------------
`define EVD_FRAME_HDR_BYTES 32'h0000_0010
`define EVD_FLAG_RETRY      31
`define EVD_FLAG_SECOND     30
`define EVD_NO_FRAME_PTR    64'hffff_ffff_ffff_ffff

// ----------------------------------------------------------------
// Vector table
// ----------------------------------------------------------------
`define EVD_PAGE_BITS       13
`define EVD_PARAM_OFF       15'h0008
`define EVD_VEC_FLOAT_DIS   15'h0010
`define EVD_VEC_ACCESS_VIO  15'h0080
`define EVD_VEC_TNV         15'h0090
`define EVD_VEC_FOR         15'h00a0
`define EVD_VEC_FOW         15'h00b0
`define EVD_VEC_FOE         15'h00c0
`define EVD_VEC_ARITH       15'h0200
`define EVD_VEC_SYS_CORR    15'h0620
`define EVD_VEC_PROC_CORR   15'h0630
`define EVD_VEC_SYS_MCHK    15'h0660
`define EVD_VEC_PROC_MCHK   15'h0670
`define EVD_IPL_SYS_CORR    5'h14
`define EVD_IPL_MCHK        5'h1f

`endif

//--- core/evd_pkg.sv
// Types shared by the exception dispatch block
package evd_pkg;

  typedef enum logic [3:0] {
    EVD_FLOAT_DIS, EVD_ACCESS_VIO, EVD_TNV, EVD_FOR, EVD_FOW, EVD_FOE,
    EVD_ARITH, EVD_SYS_CORR, EVD_PROC_CORR, EVD_SYS_MCHK, EVD_PROC_MCHK
  } evd_kind_e;

  typedef struct packed {
    evd_kind_e   kind;
    logic        frame_built;
    logic [63:0] frame_off;
    logic [15:0] pal_len;
    logic [15:0] cpu_len;
    logic [15:0] sys_len;
    logic        mchk_retry;
  } evd_event_s;

  typedef struct packed {
    logic        valid;
    logic [63:0] pc;
    logic [63:0] param;
    logic [4:0]  interrupt_priority_level;
    logic        kernel;
    logic [63:0] logout_ptr;
    logic [31:0] frame_size;
    logic [31:0] frame_flags;
    logic [31:0] cpu_off;
    logic [31:0] sys_off;
  } evd_disp_s;

endpackage

//--- core/evd_dispatch.sv
// Exception dispatch: logout frame header, vector-table fetch and handler entry state
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "evd_regs.svh"

module evd_dispatch
  import evd_pkg::*;
#(
  parameter int PA_W = 34
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Event request from the core
  input  wire evd_event_s  ev_in,
  input  wire logic        ev_valid,
  output logic             ev_ready,
  // Vector table fetch port
  output logic             mem_req,
  output logic [PA_W-1:0]  mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [63:0] mem_rdata,
  // Handler entry
  output evd_disp_s        disp
);

  localparam int PFN_W = PA_W - `EVD_PAGE_BITS;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  // Offsets reach 7FF0, so the address needs more than a page of offset
  if (PA_W < 16 || PA_W > 64) begin : g_pa_check
    $error("PA_W must lie between 16 and 64");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_VEC, ST_PARAM, ST_DONE} evd_st_e;

  typedef struct packed {
    evd_st_e          st;
    logic             aw_held;
    logic [7:0]       aw_addr;
    logic             w_held;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [PFN_W-1:0] page_frame_number;
    logic [1:0]       pend;
    logic [4:0]       interrupt_priority_level;
    evd_kind_e        last_kind;
    logic             ev_ready;
    logic [14:0]      vec_off;
    logic             mem_req;
    logic [PA_W-1:0]  mem_addr;
    evd_disp_s        disp;
  } evd_state_s;

  evd_state_s q;
  evd_state_s d;

  // Vector offset for each event class
  function automatic logic [14:0] vec_of(input evd_kind_e k);
    unique case (k)
      EVD_FLOAT_DIS:  vec_of = `EVD_VEC_FLOAT_DIS;
      EVD_ACCESS_VIO: vec_of = `EVD_VEC_ACCESS_VIO;
      EVD_TNV:        vec_of = `EVD_VEC_TNV;
      EVD_FOR:        vec_of = `EVD_VEC_FOR;
      EVD_FOW:        vec_of = `EVD_VEC_FOW;
      EVD_FOE:        vec_of = `EVD_VEC_FOE;
      EVD_ARITH:      vec_of = `EVD_VEC_ARITH;
      EVD_SYS_CORR:   vec_of = `EVD_VEC_SYS_CORR;
      EVD_PROC_CORR:  vec_of = `EVD_VEC_PROC_CORR;
      EVD_SYS_MCHK:   vec_of = `EVD_VEC_SYS_MCHK;
      EVD_PROC_MCHK:  vec_of = `EVD_VEC_PROC_MCHK;
      default:        vec_of = `EVD_VEC_PROC_MCHK;
    endcase
  endfunction

  // Machine check class, with or without correction
  function automatic logic is_mchk(input evd_kind_e k);
    is_mchk = (k == EVD_SYS_CORR) || (k == EVD_PROC_CORR) || (k == EVD_SYS_MCHK) || (k == EVD_PROC_MCHK);
  endfunction

  function automatic logic is_corr(input evd_kind_e k);
    is_corr = (k == EVD_SYS_CORR) || (k == EVD_PROC_CORR);
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic        wr_go;
    logic [31:0] wv;
    logic [31:0] rv;
    logic [1:0]  set_pend;
    logic [1:0]  clr_pend;
    logic [31:0] cpu_o;
    logic [31:0] sys_o;
    wr_go    = 1'b0;
    wv       = 32'h0000_0000;
    rv       = 32'h0000_0000;
    set_pend = 2'b00;
    clr_pend = 2'b00;
    cpu_o    = 32'h0000_0000;
    sys_o    = 32'h0000_0000;
    d        = q;
    d.disp.valid = 1'b0;

    // Write address and data are caught in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_held = 1'b1;
      d.wdata  = s_axi_wdata;
      d.wstrb  = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_held && q.w_held && !q.bvalid) begin
      wr_go     = 1'b1;
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = 2'b00;
      unique case (q.aw_addr)
        `EVD_OFF_TABLE_BASE: begin
          wv    = merge(32'(q.page_frame_number), q.wdata, q.wstrb);
          d.page_frame_number = wv[PFN_W-1:0];
        end
        `EVD_OFF_ERR_SUMMARY: begin
          if (q.wstrb[0]) begin
            clr_pend = q.wdata[1:0];
          end
        end
        `EVD_OFF_IPL: begin
          if (q.wstrb[0]) begin
            d.interrupt_priority_level = q.wdata[4:0];
          end
        end
        `EVD_OFF_STATUS: ;
        default: d.bresp = 2'b10;
      endcase
    end
    d.awready = !d.aw_held && !(q.aw_held && q.w_held);
    d.wready  = !d.w_held && !(q.aw_held && q.w_held);

    // Read channel answers one cycle after the address is taken
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp  = 2'b00;
      unique case (s_axi_araddr)
        `EVD_OFF_TABLE_BASE:  rv = 32'(q.page_frame_number);
        `EVD_OFF_ERR_SUMMARY: rv = {30'h0000_0000, q.pend};
        `EVD_OFF_IPL:         rv = {27'h000_0000, q.interrupt_priority_level};
        // Busy in bit 0, last event class code in bits 7:4
        `EVD_OFF_STATUS:      rv = {24'h00_0000, 4'(q.last_kind), 3'h0, (q.st != ST_IDLE)};
        default:              d.rresp = 2'b10;
      endcase
      d.rdata = rv;
    end
    d.arready = !d.rvalid;

    // Dispatch sequence
    unique case (q.st)
      ST_IDLE: begin
        if (ev_valid && q.ev_ready) begin
          d.last_kind = ev_in.kind;
          d.vec_off   = vec_of(ev_in.kind);
          d.mem_req   = 1'b1;
          d.mem_addr  = PA_W'({q.page_frame_number, `EVD_PAGE_BITS'(0)} + PA_W'(vec_of(ev_in.kind)));
          d.st        = ST_VEC;
          // Frame header: sections laid out back to back after the 16-byte header
          cpu_o = `EVD_FRAME_HDR_BYTES + 32'(ev_in.pal_len);
          sys_o = cpu_o + 32'(ev_in.cpu_len);
          d.disp.cpu_off    = cpu_o;
          d.disp.sys_off    = sys_o;
          d.disp.frame_size = sys_o + 32'(ev_in.sys_len);
          d.disp.frame_flags = 32'h0000_0000;
          d.disp.frame_flags[`EVD_FLAG_RETRY] = is_corr(ev_in.kind) || ev_in.mchk_retry;
          if (ev_in.kind == EVD_PROC_CORR) begin
            d.disp.frame_flags[`EVD_FLAG_SECOND] = q.pend[`EVD_BIT_PROC_PEND];
            set_pend[`EVD_BIT_PROC_PEND] = 1'b1;
          end else if (ev_in.kind == EVD_SYS_CORR) begin
            d.disp.frame_flags[`EVD_FLAG_SECOND] = q.pend[`EVD_BIT_SYS_PEND];
            set_pend[`EVD_BIT_SYS_PEND] = 1'b1;
          end
          // Only machine checks carry a frame; others see minus one
          d.disp.logout_ptr = (is_mchk(ev_in.kind) && ev_in.frame_built) ? ev_in.frame_off
                                                                         : `EVD_NO_FRAME_PTR;
          d.disp.kernel = 1'b1;
          if (ev_in.kind == EVD_SYS_CORR) begin
            d.disp.interrupt_priority_level = `EVD_IPL_SYS_CORR;
          end else if (is_mchk(ev_in.kind)) begin
            d.disp.interrupt_priority_level = `EVD_IPL_MCHK;
          end else begin
            d.disp.interrupt_priority_level = q.interrupt_priority_level;
          end
        end
      end
      ST_VEC: begin
        if (mem_ack) begin
          d.disp.pc  = mem_rdata;
          d.mem_addr = q.mem_addr + PA_W'(`EVD_PARAM_OFF);
          d.st       = ST_PARAM;
        end
      end
      ST_PARAM: begin
        if (mem_ack) begin
          d.disp.param = mem_rdata;
          d.mem_req    = 1'b0;
          d.st         = ST_DONE;
        end
      end
      ST_DONE: begin
        // Control passes only once both quadwords are in
        d.disp.valid = 1'b1;
        d.interrupt_priority_level        = q.disp.interrupt_priority_level;
        d.st         = ST_IDLE;
      end
    endcase
    d.ev_ready = (d.st == ST_IDLE) && !(q.st == ST_IDLE && ev_valid && q.ev_ready);

    // A new corrected event beats a software clear in the same cycle
    d.pend = (q.pend & ~clr_pend) | set_pend;
    if (wr_go) begin
      d.wdata = q.wdata;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q           <= '0;
      q.st        <= ST_IDLE;
      q.interrupt_priority_level       <= `EVD_IPL_RESET;
      q.last_kind <= EVD_FLOAT_DIS;
      q.disp.logout_ptr <= `EVD_NO_FRAME_PTR;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign ev_ready      = q.ev_ready;
  assign mem_req       = q.mem_req;
  assign mem_addr      = q.mem_addr;
  assign disp          = q.disp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_frame_size;
    @(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready) |=>
      q.disp.frame_size == `EVD_FRAME_HDR_BYTES + 32'($past(ev_in.pal_len)) + 32'($past(ev_in.cpu_len))
                           + 32'($past(ev_in.sys_len));
  endproperty
  AST_FRAME_SIZE: assert property (p_frame_size) else $error("frame size wrong");

  AST_RETRY_CORR: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready && is_corr(ev_in.kind)) |=> q.disp.frame_flags[31])
    else $error("retry flag clear on corrected error");

  AST_SECOND_MCHK: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready && !is_corr(ev_in.kind)) |=> !q.disp.frame_flags[30])
    else $error("second error flag set on machine check");

  AST_CPU_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready && ev_in.pal_len == 16'h0000) |=> q.disp.cpu_off == 32'h0000_0010)
    else $error("processor offset not 16 without firmware data");

  AST_SYS_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready && ev_in.sys_len == 16'h0000) |=> q.disp.sys_off == q.disp.frame_size)
    else $error("platform offset differs from size without platform data");

  AST_NO_FRAME: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready && !ev_in.frame_built) |=> q.disp.logout_ptr == 64'hffff_ffff_ffff_ffff)
    else $error("logout pointer not minus one");

  AST_FETCH_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready) |=>
      mem_req && mem_addr == PA_W'({q.page_frame_number, 13'h0000} + PA_W'(vec_of($past(ev_in.kind)))))
    else $error("entry address wrong");

  AST_PARAM_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_VEC && mem_ack) |=> mem_addr == $past(mem_addr) + PA_W'(8))
    else $error("parameter address not entry plus eight");

  AST_ARITH_IPL: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready && ev_in.kind == EVD_ARITH) |=> q.disp.interrupt_priority_level == $past(q.interrupt_priority_level) && q.disp.kernel)
    else $error("arithmetic trap level changed");

  AST_MCHK_IPL: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_IDLE && ev_valid && q.ev_ready && ev_in.kind == EVD_SYS_CORR) |=> q.disp.interrupt_priority_level == 5'h14)
    else $error("system corrected check not at level 20");

  AST_DISP_AFTER_FETCH: assert property (@(posedge aclk) disable iff (!aresetn)
    (q.st == ST_PARAM && mem_ack) |=> !disp.valid ##1 disp.valid ##1 !disp.valid)
    else $error("dispatch not two cycles after parameter fetch");

  COV_FAULT: cover property (@(posedge aclk) disable iff (!aresetn)
    (ev_valid && ev_ready && ev_in.kind == EVD_TNV) ##[1:50] disp.valid);
  COV_CORR_TWICE: cover property (@(posedge aclk) disable iff (!aresetn)
    disp.valid && disp.frame_flags[30]);
  COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid && s_axi_rready);

endmodule

`default_nettype wire

//--- dv/evd_dispatch_tb.sv
// Self-checking testbench for the exception dispatch block
`timescale 1ns/1ns
`default_nettype none
`include "evd_regs.svh"

module evd_dispatch_tb
  import evd_pkg::*;
;
  localparam int PA_W = 34;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic            aclk;
  logic            aresetn;
  logic [7:0]      awaddr;
  logic            awvalid;
  logic            awready;
  logic [31:0]     wdata;
  logic [3:0]      wstrb;
  logic            wvalid;
  logic            wready;
  logic [1:0]      bresp;
  logic            bvalid;
  logic            bready;
  logic [7:0]      araddr;
  logic            arvalid;
  logic            arready;
  logic [31:0]     rdata;
  logic [1:0]      rresp;
  logic            rvalid;
  logic            rready;
  evd_event_s      ev_in;
  logic            ev_valid;
  logic            ev_ready;
  logic            mem_req;
  logic [PA_W-1:0] mem_addr;
  logic            mem_ack;
  logic [63:0]     mem_rdata;
  evd_disp_s       disp;
  int              failures;
  int              compares;
  int              acks;
  logic            slow;
  logic [1:0]      dly;
  logic [PA_W-1:0] fetch_log [2];
  logic [PA_W-1:0] tbl_base;
  wire             go = mem_req && !mem_ack && (!slow || dly == 2'h3);

  evd_dispatch #(.PA_W(PA_W)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ev_in(ev_in), .ev_valid(ev_valid), .ev_ready(ev_ready),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .disp(disp)
  );

  // Clock: 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // Address-tagged data so a swapped or misplaced fetch shows up
  function automatic logic [63:0] pat(input logic [PA_W-1:0] a);
    return {30'h15a5_a5a5, a};
  endfunction

  // Table memory: answers each fetch, slowly when asked, and logs addresses
  always @(posedge aclk) begin
    dly       <= dly + 2'h1;
    mem_ack   <= go;
    mem_rdata <= pat(mem_addr);
    if (go) begin
      if (acks < 2) fetch_log[acks] <= mem_addr;
      acks <= acks + 1;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Readies are flops, so sampling them at the falling edge is race free
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done, w_done, aw_hs, w_hs, bv;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_hs = awready && awvalid;
      w_hs  = wready && wvalid;
      @(posedge aclk);
      if (aw_hs) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_hs) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      bv   = bvalid;
      resp = bresp;
      @(posedge aclk);
    end while (!bv);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic hs;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge aclk);
      hs = arready;
      @(posedge aclk);
    end while (!hs);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      hs   = rvalid;
      d    = rdata;
      resp = rresp;
      @(posedge aclk);
    end while (!hs);
    rready <= 1'b0;
  endtask

  // One event end to end; checks the fetch pair and the handler entry point
  task automatic run_ev(input evd_event_s e, input logic [14:0] off);
    logic            hs;
    logic [PA_W-1:0] ent;
    ent      = tbl_base + PA_W'(off);
    chk(64'(off < 15'h2000), 64'h1, "static vector in first 512 entries");
    acks     = 0;
    ev_in    <= e;
    ev_valid <= 1'b1;
    do begin
      @(negedge aclk);
      hs = ev_ready;
      @(posedge aclk);
    end while (!hs);
    ev_valid <= 1'b0;
    do @(negedge aclk); while (disp.valid !== 1'b1);
    chk(64'(acks), 64'h2, "fetch count");
    chk(64'(fetch_log[0]), 64'(ent), "vector addr");
    chk(64'(fetch_log[1]), 64'(ent + PA_W'(8)), "param addr");
    chk(disp.pc, pat(ent), "handler pc");
    chk(disp.param, pat(ent + PA_W'(8)), "handler param");
    chk(64'(disp.kernel), 64'h1, "kernel mode");
    @(posedge aclk);
  endtask

  // Corrected error or machine check with a built frame
  task automatic err_ev(input evd_kind_e k, input logic [14:0] off, input logic [15:0] p, input logic [15:0] c,
                        input logic [15:0] s, input logic rt, input logic [4:0] interrupt_priority_level, input logic rtx,
                        input logic sec);
    evd_event_s e;
    e = '0;
    e.kind        = k;
    e.frame_built = 1'b1;
    e.frame_off   = 64'h0000_0000_0000_0180;
    e.pal_len     = p;
    e.cpu_len     = c;
    e.sys_len     = s;
    e.mchk_retry  = rt;
    run_ev(e, off);
    chk(64'(disp.interrupt_priority_level), 64'(interrupt_priority_level), "handler level");
    chk(disp.logout_ptr, 64'h0000_0000_0000_0180, "logout ptr");
    chk(64'(disp.frame_size), 64'(32'd16 + p + c + s), "frame size");
    chk(64'(disp.cpu_off), 64'(32'd16 + p), "cpu offset");
    chk(64'(disp.sys_off), 64'(32'd16 + p + c), "platform_section_offset");
    chk(64'(disp.frame_flags), 64'({rtx, sec, 30'h0}), "frame flags");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    evd_kind_e   fk [7];
    logic [14:0] fo [7];
    evd_event_s  e;
    logic [31:0] d;
    logic [1:0]  r;
    fk = '{EVD_FLOAT_DIS, EVD_ACCESS_VIO, EVD_TNV, EVD_FOR, EVD_FOW, EVD_FOE, EVD_ARITH};
    fo = '{`EVD_VEC_FLOAT_DIS, `EVD_VEC_ACCESS_VIO, `EVD_VEC_TNV, `EVD_VEC_FOR, `EVD_VEC_FOW,
           `EVD_VEC_FOE, `EVD_VEC_ARITH};
    failures = 0;
    compares = 0;
    acks = 0;
    slow = 1'b0;
    dly = 2'h0;
    mem_ack = 1'b0;
    mem_rdata = '0;
    aresetn = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    ev_in = '0;
    ev_valid = 1'b0;
    tbl_base = {21'h12345, 13'h0};
    repeat (4) @(posedge aclk);
    chk(disp.logout_ptr, `EVD_NO_FRAME_PTR, "reset ptr");
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Registers: table base, level, unmapped place
    axi_wr(`EVD_OFF_TABLE_BASE, 32'h0001_2345, r);
    axi_rd(`EVD_OFF_TABLE_BASE, d, r);
    chk(64'(d), 64'h1_2345, "table base");
    axi_wr(`EVD_OFF_IPL, 32'h0000_0007, r);
    axi_rd(8'h20, d, r);
    chk(64'({r, d}), 64'h2_0000_0000, "unmapped read");
    // Faults and arithmetic trap: level kept, no frame
    for (int i = 0; i < 7; i++) begin
      e = '0;
      e.kind = fk[i];
      e.frame_off = 64'h40;
      slow = i[0];
      run_ev(e, fo[i]);
      chk(64'(disp.interrupt_priority_level), 64'h7, "level kept");
      chk(disp.logout_ptr, `EVD_NO_FRAME_PTR, "no frame ptr");
    end
    // Corrected errors: first and repeated, then machine checks
    axi_wr(`EVD_OFF_ERR_SUMMARY, 32'h0000_0003, r);
    err_ev(EVD_SYS_CORR, `EVD_VEC_SYS_CORR, 16'd0, 16'd8, 16'd0, 1'b0, `EVD_IPL_SYS_CORR, 1'b1, 1'b0);
    err_ev(EVD_SYS_CORR, `EVD_VEC_SYS_CORR, 16'd8, 16'd0, 16'd24, 1'b0, `EVD_IPL_SYS_CORR, 1'b1, 1'b1);
    err_ev(EVD_PROC_CORR, `EVD_VEC_PROC_CORR, 16'd4, 16'd4, 16'd4, 1'b0, `EVD_IPL_MCHK, 1'b1, 1'b0);
    axi_rd(`EVD_OFF_ERR_SUMMARY, d, r);
    chk(64'(d), 64'h3, "pending bits");
    slow = 1'b1;
    err_ev(EVD_SYS_MCHK, `EVD_VEC_SYS_MCHK, 16'd16, 16'd32, 16'd8, 1'b0, `EVD_IPL_MCHK, 1'b0, 1'b0);
    err_ev(EVD_PROC_MCHK, `EVD_VEC_PROC_MCHK, 16'd0, 16'd0, 16'd0, 1'b1, `EVD_IPL_MCHK, 1'b1, 1'b0);
    axi_rd(`EVD_OFF_IPL, d, r);
    chk(64'(d[4:0]), 64'h1f, "level register");
    axi_rd(`EVD_OFF_STATUS, d, r);
    chk(64'({r, d}), 64'h0_0000_00a0, "status idle, last class");
    give_verdict();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    give_verdict();
  end

endmodule
`default_nettype wire
